// ---- pkg/fieldbus_id_cfg.svh ----
// Offsets, field positions, reset values and timing of the ID override block
`ifndef FIELDBUS_ID_CFG_SVH
`define FIELDBUS_ID_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_LENGTH_WATCHDOG 4'h5
`define IDX_SOURCE_SELECT 4'h6
`define IDX_DEVICE_CODE 4'h7
`define IDX_ID_STATUS 4'h8
// Reset values
`define RST_LENGTH_WATCHDOG 8'h00
`define RST_SOURCE_SELECT 8'h00
`define RST_DEVICE_CODE 8'h00
// Field positions, length/watchdog setup
`define LW_LEN_HI 7
`define LW_LEN_LO 3
`define LW_WD_HI 1
`define LW_WD_LO 0
// Field positions, source select setup
`define SS_CODE_SEL 6
`define SS_PIN_FUNC 5
`define SS_MODE_HI 4
`define SS_MODE_LO 2
`define SS_MODE_OVR 1
`define SS_LEN_SEL 0
// Field positions, status word
`define ST_LOCKED 13
`define ST_LEN_RSVD 14
`define ST_STATUS_ERROR_INPUT 15
`define ST_BITS_LO 16
// Timing
`define CLK_PERIOD_NS 5
`define IO_ERR_FILTER_MS 270
`define PROC_WD_FILTER_NS 2500
`endif

// ---- pkg/fieldbus_id_pkg.sv ----
// Types shared by the ID override block
package fieldbus_id_pkg;
  typedef logic [12:0] id_code_t;
  typedef logic [9:0] len_bits_t;
  typedef enum logic {PIN_IO_ERROR, PIN_PROC_WATCHDOG} pin_func_t;
endpackage

// ---- rtl/fieldbus_id_code_override.sv ----
// ID code source selection with Wishbone setup registers
// Summary of operation
// [RULE_01] Length entry comes from length strap pins by default.
// [RULE_02] Software length used only while length source select is 1.
// [RULE_03] Override length bits 12..8 come from setup one bits 7..3.
// [RULE_04] Length codes 00000..01111 decode to words, nibble, bytes, bits. The code flags 01010 and 01100 as reserved.
// [RULE_05] Length codes 10000..10111 decode to words; 11xxx reserved. The code also flags 10000 as reserved.
// [RULE_06] Software programs the whole slave length, expansion included.
// [RULE_07] Code source select is bit 6, qualified by length select.
// [RULE_08] Mode override replaces mode straps with setup two bits 4..2.
// [RULE_09] Processor modes size registers from the mode table selection.
// [RULE_10] Bit 5 picks status pin: 270 ms error or 2.5 us watchdog.
// [RULE_11] Bit 5 is copied to the message bit for the master.
// [RULE_12] Both selects set: low ID byte from register 7, straps ignored.
// [RULE_13] Code override is active only while length select is set.
// [RULE_14] Code register bits 7..0 map onto ID bits 7..0.
// [RULE_15] Device code comes from code straps until override enabled.
// [RULE_16] Software sets bits 0 and 1 for internal identification.
// [RULE_17] Software overrides only before the first ID cycle.
// [RULE_18] Software writes registers 5 and 7 before register 6.
// [RULE_19] One write to register 6 after reset, then setup is locked.
// [RULE_20] Register 5 also holds the bus watchdog time in its low bits.
`include "fieldbus_id_cfg.svh"
`timescale 1ns/100ps
`default_nettype none
module fieldbus_id_code_override
#(
  parameter int unsigned IO_ERR_FILTER_CYCLES =
    `IO_ERR_FILTER_MS * 1000000 / `CLK_PERIOD_NS
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [5:2] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Strap and status pins
  input wire logic [4:0] length_strap_pins_i,
  input wire logic [7:0] code_strap_pins_i,
  input wire logic [3:0] mode_strap_pins_i,
  input wire logic status_error_input_i,
  // Identification towards the bus master
  output fieldbus_id_pkg::id_code_t id_code_o,
  output fieldbus_id_pkg::len_bits_t length_bits_o,
  output logic length_reserved_o,
  output logic message_bit_o,
  // Chip configuration
  output logic mode_table_override_o,
  output logic [2:0] mode_table_selection_o,
  output logic [3:0] mode_code_o,
  output logic [1:0] bus_watchdog_sel_o,
  output fieldbus_id_pkg::pin_func_t pin_function_o,
  output logic status_error_o,
  output logic setup_locked_o
);
  localparam int unsigned PROC_WD_FILTER_CYCLES =
    `PROC_WD_FILTER_NS / `CLK_PERIOD_NS;

  logic [7:0] length_watchdog_setup;
  logic [7:0] source_select_setup;
  logic [7:0] device_code_override;
  logic locked;
  logic [4:0] len_meta, len_sync;
  logic [7:0] code_meta, code_sync;
  logic [3:0] mode_meta, mode_sync;
  logic stat_meta, stat_sync;
  logic [25:0] filt_cnt;
  logic [25:0] filt_limit;
  logic wb_req;
  logic wb_wr;
  logic len_sel;
  logic code_sel;
  logic [10:0] next_bits;

  // Decoded length in bits; top bit flags a reserved code
  function automatic logic [10:0] decode_len(input logic [4:0] c);
    logic [10:0] r;
    r = 11'h000;
    unique case (c)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05:
        r = {2'b00, c, 4'h0};
      5'h06: r = 11'h080;
      5'h07: r = 11'h090;
      5'h08: r = 11'h004;
      5'h09: r = 11'h008;
      5'h0b: r = 11'h018;
      5'h0d: r = 11'h002;
      5'h0e: r = 11'h060;
      5'h0f: r = 11'h070;
      5'h11: r = 11'h1a0;
      5'h12: r = 11'h100;
      5'h13: r = 11'h180;
      5'h14: r = 11'h200;
      5'h15: r = 11'h0a0;
      5'h16: r = 11'h0c0;
      5'h17: r = 11'h0e0;
      default: r = 11'h400;
    endcase
    return r;
  endfunction

  assign wb_req = cyc_i && stb_i && !ack_o;
  assign wb_wr = wb_req && we_i && sel_i[0];
  assign len_sel = source_select_setup[`SS_LEN_SEL];
  // Code select means nothing without length select
  assign code_sel =
    source_select_setup[`SS_CODE_SEL] && len_sel; // RULE_07 RULE_13

  // Strap and pin synchronisers
  always_ff @(posedge clk_i)
  begin
    len_meta <= length_strap_pins_i;
    len_sync <= len_meta;
    code_meta <= code_strap_pins_i;
    code_sync <= code_meta;
    mode_meta <= mode_strap_pins_i;
    mode_sync <= mode_meta;
    stat_meta <= status_error_input_i;
    stat_sync <= stat_meta;
  end

  // Bus handshake: one wait state, ack drops the cycle after
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= wb_req;
  end

  // Setup registers; locked after the first source select write
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      length_watchdog_setup <= `RST_LENGTH_WATCHDOG;
      source_select_setup <= `RST_SOURCE_SELECT;
      device_code_override <= `RST_DEVICE_CODE;
      locked <= 1'b0;
    end
    else if (wb_wr && !locked) // RULE_19
    begin
      if (adr_i == `IDX_LENGTH_WATCHDOG)
        length_watchdog_setup <= dat_i[7:0]; // RULE_20
      if (adr_i == `IDX_DEVICE_CODE)
        device_code_override <= dat_i[7:0];
      if (adr_i == `IDX_SOURCE_SELECT)
      begin
        source_select_setup <= dat_i[7:0];
        locked <= 1'b1; // RULE_19
      end
    end
  end

  // Read data; setup registers are write only and read as zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (wb_req && !we_i && adr_i == `IDX_ID_STATUS)
    begin
      dat_o <= 32'h0000_0000;
      dat_o[12:0] <= id_code_o;
      dat_o[`ST_LOCKED] <= locked;
      dat_o[`ST_LEN_RSVD] <= length_reserved_o;
      dat_o[`ST_STATUS_ERROR_INPUT] <= status_error_o;
      dat_o[`ST_BITS_LO +: 10] <= length_bits_o;
    end
    else
      dat_o <= 32'h0000_0000;
  end

  // Effective identification code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      id_code_o <= 13'h0000;
    else
    begin
      if (len_sel)
        id_code_o[12:8] <=
          length_watchdog_setup[`LW_LEN_HI:`LW_LEN_LO]; // RULE_02 RULE_03
      else
        id_code_o[12:8] <= len_sync; // RULE_01
      if (code_sel)
        id_code_o[7:0] <= device_code_override; // RULE_12 RULE_14
      else
        id_code_o[7:0] <= code_sync; // RULE_15
    end
  end

  assign next_bits = decode_len(id_code_o[12:8]); // RULE_04 RULE_05

  // Length interpretation of the active code
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      length_bits_o <= 10'h000;
      length_reserved_o <= 1'b0;
    end
    else
    begin
      length_bits_o <= next_bits[9:0];
      length_reserved_o <= next_bits[10];
    end
  end

  // Mode table, watchdog time and pin function
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode_table_override_o <= 1'b0;
      mode_table_selection_o <= 3'h0;
      mode_code_o <= 4'h0;
      bus_watchdog_sel_o <= 2'h0;
      message_bit_o <= 1'b0;
      pin_function_o <= fieldbus_id_pkg::PIN_IO_ERROR;
    end
    else
    begin
      mode_table_override_o <= source_select_setup[`SS_MODE_OVR];
      mode_table_selection_o <=
        source_select_setup[`SS_MODE_HI:`SS_MODE_LO]; // RULE_09
      // Straps are cut off while the table is overridden
      if (source_select_setup[`SS_MODE_OVR])
        mode_code_o <= 4'h0; // RULE_08
      else
        mode_code_o <= mode_sync;
      bus_watchdog_sel_o <= length_watchdog_setup[`LW_WD_HI:`LW_WD_LO];
      message_bit_o <= source_select_setup[`SS_PIN_FUNC]; // RULE_11
      pin_function_o <= fieldbus_id_pkg::pin_func_t'(
        source_select_setup[`SS_PIN_FUNC]); // RULE_10
    end
  end

  // Status pin filter: output follows only after a stable input
  assign filt_limit = source_select_setup[`SS_PIN_FUNC] ?
    26'(PROC_WD_FILTER_CYCLES) : 26'(IO_ERR_FILTER_CYCLES); // RULE_10

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      filt_cnt <= 26'h0000000;
      status_error_o <= 1'b0;
    end
    else if (stat_sync == status_error_o)
      filt_cnt <= 26'h0000000;
    else if (filt_cnt >= filt_limit - 26'h0000001)
    begin
      filt_cnt <= 26'h0000000;
      status_error_o <= stat_sync; // RULE_10
    end
    else
      filt_cnt <= filt_cnt + 26'h0000001;
  end

  assign setup_locked_o = locked;

  // Checks
  sequence s_bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence

  sequence s_ack_pulse;
    ack_o ##1 !ack_o;
  endsequence

  a_bus_ack_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_bus_req |=> s_ack_pulse)
    else $error("ack not a one cycle answer");

  // Reset sampled low keeps the release edge out of the $past window
  a_len_from_strap: assert property ( // RULE_01
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && !len_sel |=> id_code_o[12:8] == $past(len_sync))
    else $error("length not taken from straps");

  a_len_from_setup: assert property ( // RULE_03
    @(posedge clk_i) disable iff (rst_i)
    len_sel |=> id_code_o[12:8] == $past(length_watchdog_setup[7:3]))
    else $error("length not taken from setup");

  a_code_override: assert property ( // RULE_12
    @(posedge clk_i) disable iff (rst_i)
    source_select_setup[6] && len_sel
      |=> id_code_o[7:0] == $past(device_code_override))
    else $error("code not taken from override register");

  a_code_gated: assert property ( // RULE_13
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && !len_sel |=> id_code_o[7:0] == $past(code_sync))
    else $error("code override without length select");

  a_code_strap: assert property ( // RULE_15
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && !source_select_setup[6]
      |=> id_code_o[7:0] == $past(code_sync))
    else $error("code not taken from straps");

  a_setup_locked: assert property ( // RULE_19
    @(posedge clk_i) disable iff (rst_i)
    locked |=> $stable(source_select_setup) && $stable(device_code_override)
      && $stable(length_watchdog_setup))
    else $error("setup changed after lock");

  a_message_bit: assert property ( // RULE_11
    @(posedge clk_i) disable iff (rst_i)
    $changed(source_select_setup[5]) |=> ##1
      message_bit_o == $past(source_select_setup[5], 2))
    else $error("message bit does not follow pin function");

  a_pin_function: assert property ( // RULE_10
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> pin_function_o == $past(source_select_setup[5]))
    else $error("pin function does not follow bit five");

  a_mode_cut: assert property ( // RULE_08
    @(posedge clk_i) disable iff (rst_i)
    source_select_setup[1] |=> mode_code_o == 4'h0 &&
      mode_table_selection_o == $past(source_select_setup[4:2]))
    else $error("mode straps not cut off");

  a_len_decode: assert property ( // RULE_05
    @(posedge clk_i) disable iff (rst_i)
    id_code_o[12:8] == 5'h14 |=> length_bits_o == 10'h200)
    else $error("32 word code decoded wrongly");

  a_len_reserved: assert property ( // RULE_05
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && id_code_o[12:11] == 2'b11
      |=> length_reserved_o && length_bits_o == 10'h000)
    else $error("reserved length code not flagged");

  a_wd_select: assert property ( // RULE_20
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> bus_watchdog_sel_o == $past(length_watchdog_setup[1:0]))
    else $error("watchdog time select does not follow setup");

  a_status_steady: assert property ( // RULE_10
    @(posedge clk_i) disable iff (rst_i)
    !rst_i && stat_sync == status_error_o |=> $stable(status_error_o))
    else $error("status output moved without a difference");

  a_wd_filter: assert property ( // RULE_10
    @(posedge clk_i) disable iff (rst_i)
    source_select_setup[5] && $changed(status_error_o)
      |-> $past(stat_sync) != $past(status_error_o, 500))
    else $error("watchdog filter released early");
endmodule
`default_nettype wire

// ---- tb/id_master_model.sv ----
// Fieldbus master model that latches the identification per ID cycle
`timescale 1ns/100ps
`default_nettype none
module id_master_model
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Identification cycle
  input wire logic id_cycle_i,
  input wire fieldbus_id_pkg::id_code_t id_code_i,
  output fieldbus_id_pkg::id_code_t id_seen_o,
  output logic started_o
);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      id_seen_o <= 13'h0;
      started_o <= 1'b0;
    end
    else if (id_cycle_i)
    begin
      id_seen_o <= id_code_i;
      started_o <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the ID code override block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, stat = 1'b0, idcyc = 1'b0;
  logic [3:0] adr = 4'h0, mstrap = 4'h0, mcode;
  logic [31:0] wdat = 32'h0, rdat, q, seed = 32'h0368;
  logic [4:0] lstrap = 5'h00;
  logic [7:0] cstrap = 8'h00, lw, cd, ss;
  logic [12:0] exp_id;
  logic [4:0] lc;
  logic [2:0] m, msel;
  logic [1:0] wdsel;
  logic lrsvd, msg, movr, locked, started, serr;
  fieldbus_id_pkg::id_code_t id_code, id_seen;
  fieldbus_id_pkg::len_bits_t lbits;
  fieldbus_id_pkg::pin_func_t pfunc;
  int mismatches = 0;
  int num_checks = 0;
  // Decoded length in bits per code; -1 marks a reserved code
  int lut[32] = '{0, 16, 32, 48, 64, 80, 128, 144, 4, 8, -1, 24, -1, 2, 96,
    112, -1, 416, 256, 384, 512, 160, 192, 224, -1, -1, -1, -1, -1, -1, -1, -1};

  always #2.5 clk_i = ~clk_i;

  fieldbus_id_code_override #(.IO_ERR_FILTER_CYCLES(20)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'hf), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .length_strap_pins_i(lstrap), .code_strap_pins_i(cstrap),
    .mode_strap_pins_i(mstrap), .status_error_input_i(stat),
    .id_code_o(id_code), .length_bits_o(lbits), .length_reserved_o(lrsvd),
    .message_bit_o(msg), .mode_table_override_o(movr),
    .mode_table_selection_o(msel), .mode_code_o(mcode),
    .bus_watchdog_sel_o(wdsel), .pin_function_o(pfunc),
    .status_error_o(serr), .setup_locked_o(locked));

  id_master_model master_u (.clk_i(clk_i), .rst_i(rst_i), .id_cycle_i(idcyc),
    .id_code_i(id_code), .id_seen_o(id_seen), .started_o(started));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected length field of the status word; reserved codes read zero
  function automatic logic [9:0] exp_bits(input logic [4:0] c);
    return (lut[c] < 0) ? 10'h000 : 10'(lut[c]);
  endfunction

  task automatic conclude();
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_len(input logic [4:0] c);
    chk(32'(lrsvd), 32'(lut[c] < 0));
    if (lut[c] >= 0)
      chk(32'(lbits), lut[c]);
  endtask

  // Classic single cycle; held until ack is seen at a rising edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1)
    begin
      mismatches++;
      conclude();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic reset_dut();
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  initial
  begin
    reset_dut();
    for (int c = 0; c < 32; c++)
    begin
      lstrap <= c[4:0];
      cstrap <= 8'(rnd());
      mstrap <= 4'(rnd());
      repeat (6) @(posedge clk_i);
      chk(32'(id_code), {19'h0, lstrap, cstrap});
      chk(32'(mcode), 32'(mstrap));
      check_len(lstrap);
    end
    stat <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk(32'(serr), 32'h0);
    repeat (20) @(posedge clk_i);
    chk(32'(serr), 32'h1);
    for (int r = 0; r < 2; r++)
    begin
      stat <= 1'b1;
      reset_dut();
      repeat (30) @(posedge clk_i);
      lw = 8'(rnd());
      cd = 8'(rnd());
      m = 3'(rnd());
      ss = {1'b0, 1'b1, 1'b1, m, 1'b1, r[0]};
      wb(1'b1, 4'h5, lw);
      wb(1'b1, 4'h7, cd);
      chk(32'(started), 32'h0);
      chk(32'(locked), 32'h0);
      wb(1'b1, 4'h6, ss);
      chk(32'(locked), 32'h1);
      wb(1'b0, 4'h5, 8'h00);
      chk(q, 32'h0);
      wb(1'b0, 4'hf, 8'h00);
      chk(q, 32'h0);
      wb(1'b1, 4'h5, ~lw);
      wb(1'b1, 4'h6, 8'h00);
      repeat (4) @(posedge clk_i);
      exp_id = r[0] ? {lw[7:3], cd} : {lstrap, cstrap};
      chk(32'(id_code), 32'(exp_id));
      check_len(r[0] ? lw[7:3] : lstrap);
      chk(32'(msg), 32'h1);
      chk(32'(pfunc), 32'h1);
      chk(32'({movr, msel, mcode}), 32'({1'b1, m, 4'h0}));
      chk(32'(wdsel), 32'(lw[1:0]));
      wb(1'b0, 4'h8, 8'h00);
      lc = exp_id[12:8];
      chk(q, {6'h0, exp_bits(lc), 1'b1, lut[lc] < 0, 1'b1, exp_id});
      idcyc <= 1'b1;
      @(posedge clk_i);
      idcyc <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk(32'(id_seen), 32'(exp_id));
      stat <= 1'b0;
      repeat (100) @(posedge clk_i);
      chk(32'(serr), 32'h1);
      repeat (450) @(posedge clk_i);
      chk(32'(serr), 32'h0);
    end
    conclude();
  end
endmodule
`default_nettype wire
